// [qrd_pkg.sv]
// constants, types and field layout for the quad read sequencer
// assumes: compiled before every other file of the block
// Contract
// - quad read takes 24-bit address, nibble data
// - quad read waits four dummy clocks
// - quad read needs quad lines enabled
// - low mode nibble is ignored
// - mode bits 10 skip the next opcode
// - other mode bits restore opcode decoding
// - mode reset instruction clears latched mode
// - wrap setting governs later quad reads
// - wrap confines reads to aligned section
// - wrap starts at address, loops until deselect
// - wrap setting is enable plus length
// - word read uses two dummy clocks
// - word read needs quad lines enabled
// - word read may skip next opcode
// - wrap setting applies to word reads
// - octal word read has no dummy clocks
// - octal word read needs quad lines enabled
// - octal word read may skip next opcode
// - skipped opcode saves eight clocks
// - eight all-ones clocks release mode
// - wrap instruction: opcode, dummies, wrap bits
package qrd_pkg;

  // instruction codes
  localparam logic [7:0] OPC_QUAD_READ  = 8'hEB;
  localparam logic [7:0] OPC_WORD_READ  = 8'hE7;
  localparam logic [7:0] OPC_OCTAL_READ = 8'hE3;
  localparam logic [7:0] OPC_SET_WRAP   = 8'h77;
  localparam logic [7:0] OPC_MODE_RESET = 8'hFF;

  // last count of each phase, and dummy lengths, in serial clocks
  localparam logic [4:0] OPC_LAST       = 5'h07;
  localparam logic [4:0] ADDR_LAST      = 5'h05;
  localparam logic [4:0] MODE_LAST      = 5'h01;
  localparam logic [4:0] WRAP_DMY_LAST  = 5'h05;
  localparam logic [4:0] WRAP_BITS_LAST = 5'h01;
  localparam logic [4:0] DUMMY_QUAD     = 5'h04;
  localparam logic [4:0] DUMMY_WORD     = 5'h02;
  localparam logic [4:0] DUMMY_OCTAL    = 5'h00;

  // field positions within the high nibble of mode and wrap bytes
  localparam logic [1:0] SKIP_CODE      = 2'b10;
  localparam int         SKIP_HI        = 1;
  localparam int         SKIP_LO        = 0;
  localparam int         WRAP_DIS_POS   = 0;
  localparam int         WRAP_LEN_HI    = 2;
  localparam int         WRAP_LEN_LO    = 1;

  // reset values, and the smallest wrap section in bytes
  localparam logic       WRAP_DIS_RST   = 1'b1;
  localparam logic [1:0] WRAP_LEN_RST   = 2'b00;
  localparam logic [7:0] MODE_BYTE_RST  = 8'h00;
  localparam int         WRAP_BASE_BYTES = 8;

  // wrap setting carrier
  typedef struct packed {
    logic       wrap_disable_bit;
    logic [1:0] wrap_length_field;
  } qrd_wrap_s;

  // quad line drive carrier
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] enable;
  } qrd_pins_s;

  // read instruction kinds, one-hot
  typedef enum logic [2:0] {
    KIND_QUAD  = 3'b001,
    KIND_WORD  = 3'b010,
    KIND_OCTAL = 3'b100
  } qrd_kind_e;

  // frame states, one-hot
  typedef enum logic [8:0] {
    ST_START     = 9'b0_0000_0001,
    ST_OPCODE    = 9'b0_0000_0010,
    ST_ADDR      = 9'b0_0000_0100,
    ST_MODE      = 9'b0_0000_1000,
    ST_DUMMY     = 9'b0_0001_0000,
    ST_DATA      = 9'b0_0010_0000,
    ST_WRAP_DMY  = 9'b0_0100_0000,
    ST_WRAP_BITS = 9'b0_1000_0000,
    ST_IGNORE    = 9'b1_0000_0000
  } qrd_state_e;

endpackage

// [qrd_sync.sv]
// two-flop level synchroniser, any width
// assumes: each bit is a quasi-static level in the source domain
`timescale 1ns/10ps
module qrd_sync #(
  parameter int WIDTH = 1
) (
  // destination clock and synchronous reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // source level and its synchronised copy
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;  // first stage, read by second only

  // two stages, cleared by reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule

// [qrd_wrap_step.sv]
// next read address, linear or wrapped inside an aligned section
// assumes: section lengths are powers of two, so sections never cross a page
`timescale 1ns/10ps
module qrd_wrap_step #(
  parameter int ADDR_W = 24
) (
  // current address and wrap setting
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire qrd_pkg::qrd_wrap_s wrap_i,
  // address of the following byte
  output logic      [ADDR_W-1:0] next_o
);
  import qrd_pkg::*;

  logic [ADDR_W-1:0] span;  // section length in bytes
  logic [ADDR_W-1:0] mask;  // offset bits inside the section
  logic [ADDR_W-1:0] inc;   // plain increment

  // pick linear or wrapped step
  always_comb begin
    span = ADDR_W'(WRAP_BASE_BYTES) << wrap_i.wrap_length_field;
    mask = span - ADDR_W'(1);
    inc  = addr_i + ADDR_W'(1);
    if (wrap_i.wrap_disable_bit) begin
      next_o = inc;
    end else begin
      next_o = (addr_i & ~mask) | (inc & mask);
    end
  end

endmodule

// [qrd_quad_read.sv]
// quad-line read sequencer: opcode, address, mode byte, dummies, data
// assumes: host drives sclk_i and cs_n_i; sclk_i may stop while deselected;
// the memory answers mem_rd_data_i combinationally within half a sclk period
// sys_rst_i only reaches link state while sclk_i runs; the host must clock
// a few idle cycles during and after reset before its first frame
`timescale 1ns/10ps
module qrd_quad_read #(
  parameter int ADDR_W = 24
) (
  // system clock and reset
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // configuration and status, system domain
  input  wire logic              quad_lines_enable_i,
  output logic                   crm_active_o,
  output logic                   wrap_active_o,
  // serial link from the host
  input  wire logic              sclk_i,
  input  wire logic              cs_n_i,
  input  wire logic [3:0]        quad_line_i,
  output logic      [3:0]        quad_line_o,
  output logic      [3:0]        quad_line_oe_o,
  // memory array read port, link domain
  output logic                   mem_rd_en_o,
  output logic      [ADDR_W-1:0] mem_rd_addr_o,
  input  wire logic [7:0]        mem_rd_data_i
);
  import qrd_pkg::*;

  // the link logic runs entirely on sclk_i; only the reset and the quad enable level
  // enter from the system side and only two status levels leave it, each
  // through a two-flop synchroniser, so no multi-bit word ever crosses
  // crossings
  logic              rst_link;     // system reset seen on the link clock
  logic              qe_link;      // quad enable seen on the link clock
  logic [1:0]        stat_sys;     // link status seen on the system clock

  // frame state, cleared whenever the host deselects
  qrd_state_e        state_reg;
  qrd_state_e        state_next;
  logic [4:0]        cnt_reg;      // clocks spent in current phase
  logic [4:0]        cnt_next;
  logic [6:0]        opc_sh_reg;   // opcode bits so far
  logic [3:0]        hold_reg;     // high nibble of mode or wrap byte
  qrd_kind_e         kind_reg;     // read kind of this frame
  qrd_kind_e         kind_next;
  logic [ADDR_W-1:0] addr_reg;     // byte address being read
  logic [ADDR_W-1:0] addr_step;    // following byte address
  logic              half_reg;     // low nibble goes out next
  logic [4:0]        dummy_len;    // dummy clocks for this kind
  logic [7:0]        opc_full;     // opcode completed this clock

  // none of these are touched by deselect; only the synchronised reset and completed mode, wrap or reset instructions change them
  // state kept between frames
  logic [7:0]        read_mode_byte_reg; // last mode byte received
  logic              crm_reg;            // opcode skipped next frame
  qrd_kind_e         crm_kind_reg;       // kind repeated when skipping
  qrd_wrap_s         wrap_reg;           // wrap setting bits

  // phase events
  logic              mode_done;    // mode byte complete
  logic              wrap_done;    // wrap byte complete
  logic              mode_clear;   // reset instruction seen

  // falling edge drive
  qrd_pins_s         pins_reg;

  // the flops of this synchroniser have no reset of their own
  // system reset into link domain; the link clock must run for it to act
  qrd_sync #(
    .WIDTH (1)
  ) u_rst_sync (
    .clk_i (sclk_i),
    .rst_i (1'b0),
    .d_i   (sys_rst_i),
    .q_o   (rst_link)
  );

  // quad enable into link domain
  qrd_sync #(
    .WIDTH (1)
  ) u_qe_sync (
    .clk_i (sclk_i),
    .rst_i (rst_link),
    .d_i   (quad_lines_enable_i),
    .q_o   (qe_link)
  );

  // each status bit is a slow level, so bitwise synchronising is safe
  // status levels back into system domain
  qrd_sync #(
    .WIDTH (2)
  ) u_stat_sync (
    .clk_i (clk_i),
    .rst_i (sys_rst_i),
    .d_i   ({crm_reg, ~wrap_reg.wrap_disable_bit}),
    .q_o   (stat_sys)
  );

  // status outputs straight from synchroniser flops
  assign crm_active_o  = stat_sys[1];
  assign wrap_active_o = stat_sys[0];

  // pure logic; the wrap setting cannot change inside a read frame
  // address stepping, honouring the wrap setting
  qrd_wrap_step #(
    .ADDR_W (ADDR_W)
  ) u_step (
    .addr_i (addr_reg),
    .wrap_i (wrap_reg),
    .next_o (addr_step)
  );

  // the octal word read has no dummies: data follows the mode byte at once
  // dummy length per read kind
  always_comb begin
    case (kind_reg)
      KIND_QUAD:  dummy_len = DUMMY_QUAD;
      KIND_WORD:  dummy_len = DUMMY_WORD;
      KIND_OCTAL: dummy_len = DUMMY_OCTAL;
      default:    dummy_len = DUMMY_QUAD;
    endcase
  end

  // the opcode is complete on the eighth rising edge of the frame
  assign opc_full = {opc_sh_reg, quad_line_i[0]};

  // one frame is one pass through this machine: start, then either the
  // opcode or, with the skip latched and quad enable on, straight to the address; the read
  // kind chosen here fixes the dummy length for the rest of the frame;
  // anything not recognised parks in the ignore state until deselect
  // next state of the frame
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 5'h01;
    kind_next  = kind_reg;
    mode_done  = 1'b0;
    wrap_done  = 1'b0;
    mode_clear = 1'b0;
    case (state_reg)
      // first clock: address nibble or opcode bit
      ST_START: begin
        if (crm_reg && qe_link) begin
          state_next = ST_ADDR;
          kind_next  = crm_kind_reg;
        end else begin
          state_next = ST_OPCODE;
        end
      end
      // rest of the opcode, one bit a clock on line 0
      ST_OPCODE: begin
        if (cnt_reg == OPC_LAST) begin
          cnt_next = 5'h00;
          if (opc_full == OPC_QUAD_READ && qe_link) begin
            state_next = ST_ADDR;
            kind_next  = KIND_QUAD;
          end else if (opc_full == OPC_WORD_READ && qe_link) begin
            state_next = ST_ADDR;
            kind_next  = KIND_WORD;
          end else if (opc_full == OPC_OCTAL_READ && qe_link) begin
            state_next = ST_ADDR;
            kind_next  = KIND_OCTAL;
          end else if (opc_full == OPC_SET_WRAP && qe_link) begin
            state_next = ST_WRAP_DMY;
          end else if (opc_full == OPC_MODE_RESET) begin
            state_next = ST_IGNORE;
            mode_clear = 1'b1;
          end else begin
            state_next = ST_IGNORE;
          end
        end
      end
      // six address nibbles
      ST_ADDR: begin
        if (cnt_reg == ADDR_LAST) begin
          state_next = ST_MODE;
          cnt_next   = 5'h00;
        end
      end
      // two mode nibbles
      ST_MODE: begin
        if (cnt_reg == MODE_LAST) begin
          mode_done = 1'b1;
          cnt_next  = 5'h00;
          if (dummy_len == DUMMY_OCTAL) begin
            state_next = ST_DATA;
          end else begin
            state_next = ST_DUMMY;
          end
        end
      end
      // dummy clocks before data
      ST_DUMMY: begin
        if (cnt_reg == dummy_len - 5'h01) begin
          state_next = ST_DATA;
          cnt_next   = 5'h00;
        end
      end
      // data streams until deselect
      // the count is frozen; byte pairing is kept by half_reg
      ST_DATA: begin
        cnt_next = cnt_reg;
      end
      // dummy nibbles of the wrap instruction
      ST_WRAP_DMY: begin
        if (cnt_reg == WRAP_DMY_LAST) begin
          state_next = ST_WRAP_BITS;
          cnt_next   = 5'h00;
        end
      end
      // two wrap nibbles
      ST_WRAP_BITS: begin
        if (cnt_reg == WRAP_BITS_LAST) begin
          state_next = ST_IGNORE;
          wrap_done  = 1'b1;
        end
      end
      // nothing more until deselect
      ST_IGNORE: begin
        cnt_next = cnt_reg;
      end
      default: begin
        state_next = ST_IGNORE;
      end
    endcase
  end

  // deselect is the only way out of a frame, so it clears the frame state
  // asynchronously; sclk_i may already have stopped when cs_n_i rises
  // frame state, cleared by deselect
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      state_reg <= ST_START;
      cnt_reg   <= 5'h00;
      kind_reg  <= KIND_QUAD;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= (state_reg == ST_START) ? 5'h01 : cnt_next;
      kind_reg  <= kind_next;
    end
  end

  // only seven bits are kept; the eighth is read straight off line 0
  // opcode shifter, line 0 only
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      opc_sh_reg <= 7'h00;
    end else if (state_reg == ST_START || state_reg == ST_OPCODE) begin
      opc_sh_reg <= {opc_sh_reg[5:0], quad_line_i[0]};
    end
  end

  // the first nibble of a two-nibble byte is parked here until the second
  // high nibble holder for mode and wrap bytes
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      hold_reg <= 4'h0;
    end else if ((state_reg == ST_MODE || state_reg == ST_WRAP_BITS)
                 && cnt_reg == 5'h00) begin
      hold_reg <= quad_line_i;
    end
  end

  // in a skipped frame the first address nibble arrives in the start
  // state, so the shift is enabled there as well; in the data phase the
  // address steps only after the low nibble has gone out
  // address: shifted in a nibble a clock, then stepped per byte
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      addr_reg <= '0;
    end else if ((state_reg == ST_START && crm_reg && qe_link)
                 || state_reg == ST_ADDR) begin
      addr_reg <= {addr_reg[ADDR_W-5:0], quad_line_i};
    end else if (state_reg == ST_DATA && half_reg) begin
      addr_reg <= addr_step;
    end
  end

  // high nibble first, so the selector starts at zero in every frame
  // nibble selector inside data phase
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      half_reg <= 1'b0;
    end else if (state_reg == ST_DATA) begin
      half_reg <= ~half_reg;
    end
  end

  // this latch lives across frames and is cleared only by reset, by a
  // mode byte without the skip code, or by the all-ones reset opcode;
  // mode_done and mode_clear never fall in one clock, so no set and clear race
  // continuous read mode latch, survives deselect
  always_ff @(posedge sclk_i) begin
    if (rst_link) begin
      read_mode_byte_reg <= MODE_BYTE_RST;
      crm_reg            <= 1'b0;
      crm_kind_reg       <= KIND_QUAD;
    end else if (mode_done) begin
      // only the high nibble decides
      read_mode_byte_reg <= {hold_reg, quad_line_i};
      crm_reg            <= (hold_reg[SKIP_HI:SKIP_LO] == SKIP_CODE);
      crm_kind_reg       <= kind_reg;
    end else if (mode_clear) begin
      read_mode_byte_reg <= MODE_BYTE_RST;
      crm_reg            <= 1'b0;
    end
  end

  // the wrap byte arrives in nibble form; only its high nibble carries
  // the disable bit and the length field, the low nibble is dropped
  // wrap setting, disabled after reset
  always_ff @(posedge sclk_i) begin
    if (rst_link) begin
      wrap_reg.wrap_disable_bit  <= WRAP_DIS_RST;
      wrap_reg.wrap_length_field <= WRAP_LEN_RST;
    end else if (wrap_done) begin
      wrap_reg.wrap_disable_bit  <= hold_reg[WRAP_DIS_POS];
      wrap_reg.wrap_length_field <= hold_reg[WRAP_LEN_HI:WRAP_LEN_LO];
    end
  end

  // the array is read combinationally from the address register; the
  // falling edge flop below picks the nibble half a clock later
  // memory port follows the address register
  assign mem_rd_en_o   = (state_reg == ST_DATA);
  assign mem_rd_addr_o = addr_reg;

  // driving from the falling edge gives the host a full half period of
  // setup before it samples on the next rising edge; the host must have
  // released the lines before the first of these falling edges
  // data out on the falling edge; lines released on deselect
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      pins_reg <= '0;
    end else if (state_reg == ST_DATA) begin
      pins_reg.enable <= 4'hF;
      pins_reg.level  <= half_reg ? mem_rd_data_i[3:0] : mem_rd_data_i[7:4];
    end else begin
      pins_reg <= '0;
    end
  end

  // pin outputs from the falling edge flops
  assign quad_line_o    = pins_reg.level;
  assign quad_line_oe_o = pins_reg.enable;

endmodule

// [qrd_checker.sv]
// port assertions for the quad read sequencer
// assumes: bound to qrd_quad_read, link idle clocks come with cs high
`timescale 1ns/10ps
module qrd_checker #(
  parameter int ADDR_W = 24
) (
  // system domain
  input wire logic              clk_i,
  input wire logic              sys_rst_i,
  input wire logic              quad_lines_enable_i,
  input wire logic              wrap_active_o,
  // link domain
  input wire logic              sclk_i,
  input wire logic              cs_n_i,
  input wire logic [3:0]        quad_line_o,
  input wire logic [3:0]        quad_line_oe_o,
  input wire logic              mem_rd_en_o,
  input wire logic [ADDR_W-1:0] mem_rd_addr_o
);
  logic [7:0] edge_cnt; // sclk edges since select fell
  // frame edge counter, cleared while deselected
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) edge_cnt <= 8'h00;
    else edge_cnt <= edge_cnt + 8'h01;
  end
  // three data samples in a row
  sequence s_stream;
    mem_rd_en_o [*3];
  endsequence
  // quad enable low, then a new frame
  sequence s_qe_off;
    !quad_lines_enable_i [*4] ##1 $fell(cs_n_i);
  endsequence
  a_idle_no_drive: assert property (@(posedge sclk_i) disable iff (sys_rst_i)
    cs_n_i |-> quad_line_oe_o == 4'h0 && quad_line_o == 4'h0)
    else $error("lines driven while deselected");
  a_all_four: assert property (@(posedge sclk_i) disable iff (sys_rst_i)
    quad_line_oe_o == 4'hF
    || (quad_line_oe_o == 4'h0 && !(mem_rd_en_o && $past(mem_rd_en_o))))
    else $error("partial line drive");
  a_reset_wrap_off: assert property (@(posedge clk_i)
    sys_rst_i ##1 sys_rst_i |-> !wrap_active_o)
    else $error("wrap status set during reset");
  a_drive_in_data: assert property (@(posedge sclk_i) disable iff (sys_rst_i)
    quad_line_oe_o != 4'h0 |-> mem_rd_en_o)
    else $error("drive outside data phase");
  a_drive_start: assert property (@(posedge sclk_i) disable iff (sys_rst_i)
    $rose(mem_rd_en_o) |-> quad_line_oe_o == 4'hF && $past(quad_line_oe_o) == 4'h0)
    else $error("data drive start misplaced");
  a_dummy_count: assert property (@(posedge sclk_i) disable iff (sys_rst_i)
    $rose(mem_rd_en_o) |-> edge_cnt inside {8'h08, 8'h0A, 8'h0C, 8'h10, 8'h12, 8'h14})
    else $error("data phase at wrong clock count");
  a_addr_linear: assert property (@(posedge sclk_i) disable iff (sys_rst_i)
    s_stream ##0 !wrap_active_o |-> mem_rd_addr_o == $past(mem_rd_addr_o, 2) + 1'b1)
    else $error("linear address step wrong");
  a_wrap_section: assert property (@(posedge sclk_i) disable iff (sys_rst_i)
    s_stream ##0 wrap_active_o |-> mem_rd_addr_o != $past(mem_rd_addr_o, 2)
    && mem_rd_addr_o[ADDR_W-1:6] == $past(mem_rd_addr_o[ADDR_W-1:6], 2))
    else $error("wrapped address left section");
  a_refused_quiet: assert property (@(posedge sclk_i) disable iff (sys_rst_i)
    s_qe_off |-> (quad_line_oe_o == 4'h0 && !mem_rd_en_o) [*8])
    else $error("frame served without quad enable");
endmodule

bind qrd_quad_read qrd_checker #(.ADDR_W(ADDR_W)) chk_i (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .quad_lines_enable_i(quad_lines_enable_i),
  .wrap_active_o(wrap_active_o), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .quad_line_o(quad_line_o), .quad_line_oe_o(quad_line_oe_o),
  .mem_rd_en_o(mem_rd_en_o), .mem_rd_addr_o(mem_rd_addr_o));

// [qrd_host.sv]
// host controller model: chip select, serial clock, quad lines
// assumes: bench merges this level with the device drive into the pins
`timescale 1ns/10ps
module qrd_host (
  // link outputs
  output logic       sclk_o,
  output logic       cs_n_o,
  output logic [3:0] line_o,
  // resolved pin level
  input  wire logic [3:0] pin_i
);
  logic [7:0] rx_q[$]; // bytes read back
  logic [3:0] nib;     // nibble taken at rise
  logic [3:0] hi_nib;  // pending high nibble
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    line_o = 4'h5;
  end
  // one clock: drive, rise and sample, optional release, fall
  task automatic tick(input logic [3:0] v, input logic rel);
    line_o = v;
    #16 sclk_o = 1'b1;
    nib = pin_i;
    #8 if (rel) line_o = ~line_o;
    #8 sclk_o = 1'b0;
  endtask
  // idle clocks with select high
  task automatic run(input int n);
    repeat (n) tick(~line_o, 1'b0);
  endtask
  // one frame; skip leaves the opcode out, released lines toggle
  task automatic frame(input logic [7:0] op, input logic skip, input logic [23:0] a,
                       input logic [7:0] m, input int dmy, input int nb);
    rx_q = {};
    cs_n_o = 1'b0;
    if (!skip) for (int i = 7; i >= 0; i--) tick({3'b000, op[i]}, 1'b0);
    for (int i = 5; i >= 0; i--) tick(a[4*i+:4], 1'b0);
    tick(m[7:4], 1'b0);
    tick(m[3:0], 1'b1);
    for (int i = 0; i < dmy + 2 * nb; i++) begin
      tick(~line_o, 1'b0);
      if (i >= dmy && (i - dmy) % 2 == 1) rx_q.push_back({hi_nib, nib});
      else hi_nib = nib;
    end
    cs_n_o = 1'b1;
    tick(~line_o, 1'b0);
  endtask
endmodule

// [testbench.sv]
// self-checking bench for the quad read sequencer
// assumes: host model owns the link; memory byte is a fixed address hash
`timescale 1ns/10ps
module testbench;
  import qrd_pkg::*;
  logic        clk_i = 1'b0;     // system clock
  logic        sys_rst_i = 1'b1; // system reset
  logic        qe = 1'b0;        // quad enable level
  logic        sclk, cs_n, crm, wrap, oe_seen;
  logic [3:0]  hd, dq, doe, pin;
  logic [23:0] addr;
  logic [7:0]  mdata;
  int          err_total = 0;
  int          tests_run = 0;
  // 20 MHz system clock
  always #25 clk_i = ~clk_i;
  // pins: device drive wins where enabled
  assign pin = (dq & doe) | (hd & ~doe);
  // memory byte for any address
  assign mdata = addr[7:0] ^ addr[15:8] ^ 8'h5A;
  // any device drive during a frame
  always @(posedge sclk) if (doe != 4'h0) oe_seen = 1'b1;
  qrd_host host_i (.sclk_o(sclk), .cs_n_o(cs_n), .line_o(hd), .pin_i(pin));
  qrd_quad_read qrd_quad_read_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .quad_lines_enable_i(qe),
    .crm_active_o(crm), .wrap_active_o(wrap), .sclk_i(sclk), .cs_n_i(cs_n),
    .quad_line_i(pin), .quad_line_o(dq), .quad_line_oe_o(doe), .mem_rd_en_o(),
    .mem_rd_addr_o(addr), .mem_rd_data_i(mdata));
  // compare and count
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // status after the sync delay
  task automatic st(input logic c, input logic w);
    repeat (4) @(negedge clk_i);
    check("crm", {23'h0, c}, {23'h0, crm});
    check("wrap", {23'h0, w}, {23'h0, wrap});
  endtask
  // read and compare nb bytes; wl is wrap length or zero
  task automatic rd(input logic [7:0] op, input logic skip, input logic [23:0] a,
                    input logic [7:0] md, input int dmy, input int nb, input int wl);
    logic [23:0] x, m;
    x = a;
    m = 24'(wl - 1);
    host_i.frame(op, skip, a, md, dmy, nb);
    for (int i = 0; i < nb; i++) begin
      check("byte", {16'h0, x[7:0] ^ x[15:8] ^ 8'h5A}, {16'h0, host_i.rx_q[i]});
      x = (wl == 0) ? x + 24'h1 : (x & ~m) | ((x + 24'h1) & m);
    end
  endtask
  // quad reads refused without quad enable
  task automatic t_refuse;
    logic [7:0] ops[3] = '{8'hEB, 8'hE7, 8'hE3};
    foreach (ops[k]) begin
      oe_seen = 1'b0;
      host_i.frame(ops[k], 1'b0, 24'h00_0100, 8'h20, 4, 2);
      check("drive", 24'h0, {23'h0, oe_seen});
    end
    st(1'b0, 1'b0);
    $display("refuse test done");
  endtask
  // opcode skip set, used and dropped for each read kind
  task automatic t_crm;
    logic [7:0] ops[3] = '{8'hEB, 8'hE7, 8'hE3};
    int         dm[3] = '{4, 2, 0};
    foreach (ops[k]) begin
      rd(ops[k], 1'b0, 24'h01_2340, 8'hE5, dm[k], 3, 0);
      st(1'b1, 1'b0);
      rd(ops[k], 1'b1, 24'hAB_CD10, 8'h25, dm[k], 3, 0);
      st(1'b1, 1'b0);
      rd(ops[k], 1'b1, 24'h00_0FF0, 8'h30, dm[k], 2, 0);
      st(1'b0, 1'b0);
    end
    $display("skip test done");
  endtask
  // eight all-ones clocks release the skip
  task automatic t_mode_reset;
    rd(8'hEB, 1'b0, 24'h00_0040, 8'h20, 4, 1, 0);
    st(1'b1, 1'b0);
    host_i.frame(8'hFF, 1'b1, 24'hFF_FFFF, 8'hFF, 0, 0);
    st(1'b0, 1'b0);
    rd(8'hEB, 1'b0, 24'h00_0080, 8'h20, 4, 1, 0);
    st(1'b1, 1'b0);
    // skip not applied without quad enable: the opcode path clears it
    @(posedge clk_i);
    qe <= 1'b0;
    host_i.run(4);
    host_i.frame(8'hFF, 1'b0, 24'h00_0000, 8'h00, 0, 0);
    st(1'b0, 1'b0);
    @(posedge clk_i);
    qe <= 1'b1;
    host_i.run(4);
    rd(8'hEB, 1'b0, 24'h00_FFFE, 8'h00, 4, 4, 0);
    $display("mode reset test done");
  endtask
  // every wrap length, then wrap off again
  task automatic t_wrap;
    int l;
    for (int c = 0; c < 4; c++) begin
      l = 8 << c;
      host_i.frame(8'h77, 1'b0, 24'h00_0000, {1'b0, c[1:0], 5'h00}, 0, 0);
      st(1'b0, 1'b1);
      rd(c[0] ? 8'hE7 : 8'hEB, 1'b0, 24'h00_4200 + 24'(l - 2), 8'h00,
         c[0] ? 2 : 4, l + 2, l);
    end
    host_i.frame(8'h77, 1'b0, 24'h00_0000, 8'h70, 0, 0);
    st(1'b0, 1'b0);
    rd(8'hEB, 1'b0, 24'h00_423E, 8'h00, 4, 4, 0);
    $display("wrap test done");
  endtask
  // closing report
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard
  initial begin
    #2_000_000;
    err_total++;
    print_verdict();
  end
  // main sequence
  initial begin
    fork
      host_i.run(16);
      repeat (12) @(posedge clk_i);
    join
    sys_rst_i <= 1'b0;
    host_i.run(4);
    t_refuse();
    @(posedge clk_i);
    qe <= 1'b1;
    host_i.run(4);
    t_crm();
    t_mode_reset();
    t_wrap();
    print_verdict();
  end
endmodule
